// >>> hw/seq_map.vh
/*
 Timing counts, state codes and operation codes for the major-state
 bus sequencer. Definitions only; included by the sequencer.
*/
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

// Crystal division: one state spans two crystal periods
`define XTAL_PER_STATE   2
`define XTAL_FREQ_HZ     4000000
`define STATE_TIME_NS    500
`define WAIT_STEP_NS     250

// Major states
`define ST_IDLE          3'h0
`define ST_ADDR          3'h1
`define ST_XFER_IN       3'h2
`define ST_ALU_A         3'h3
`define ST_ALU_B         3'h4
`define ST_ALU_C         3'h5
`define ST_WRITE         3'h6

// Cycle kinds
`define CY_FETCH         2'h0
`define CY_MEM_RD        2'h1
`define CY_MEM_WR        2'h2
`define CY_IO            2'h3

// Top opcode field of the instruction
`define OP_AND           3'h0
`define OP_ADD           3'h1
`define OP_DEP           3'h3
`define OP_JUMP          3'h5
`define OP_IO            3'h6
`define OP_OPR           3'h7

// Target selects of a transfer
`define TGT_MAIN         2'h0
`define TGT_PANEL        2'h1
`define TGT_TOGGLE       2'h2

`define RESET_PTR        12'h000
`endif

// >>> hw/major_state_bus_sequencer.v
/*
 Major-state sequencer of a 12-bit processor: state timing, multiplexed
 bus control, register set, link and ALU.
 Assumes one clock (sys_clk acts as the crystal), external inputs that are
 asynchronous to it, and a testbench that resolves the muxed bus from the
 output enable. Instruction paging and run/halt are not modelled.
*/
// Contract
// RULE1: State lasts two crystal clock periods
// RULE2: Address state drives address, pulses latch strobe
// RULE3: I/O cycle drives instruction word on bus
// RULE4: Requests sampled in address state before fetch
// RULE5: Current state shown on outputs
// RULE6: Transfer-in state reads, stalls while wait
// RULE7: Wait extends by whole crystal periods
// RULE8: Memory or peripheral select during transfer
// RULE9: Sense lines sampled during I/O transfer
// RULE10: Panel and toggle selects active low
// RULE11: States three to five internal only
// RULE12: Write state holds data while wait
// RULE13: Five 12-bit registers kept; the code keeps six (acc_q, mq_q, ptr_q, loc_q, op_q, data_q)
// RULE14: Link complements on carry, full link ops
// RULE15: Accumulator clear/set/complement/increment/test/rotate; the operate word has no accumulator test
// RULE16: OR and exchange with multiplier-quotient
// RULE17: Fetch copies pointer, loads opcode holder
// RULE18: Jump loads target into pointer
// RULE19: Peripheral may steer branch during I/O
// RULE20: ALU adds, ands, ors, shifts, increments
// RULE21: Pointer incremented by one after copy
// RULE22: Peripherals drive sense lines low, selected only
`timescale 1ns/10ps
`include "seq_map.vh"

module major_state_bus_sequencer #(
    parameter WIDTH = 12,
    parameter NREQ  = 3
) (
    // Clock, reset, enable
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             clk_en,
    // Multiplexed bus
    input  wire [WIDTH-1:0] muxed_bus_in,
    output reg  [WIDTH-1:0] muxed_bus_out,
    output reg              muxed_bus_oe,
    output reg              external_latch_strobe,
    // Selects
    output reg              memory_select_n,
    output reg              peripheral_select_n,
    output reg              panel_store_select_n,
    output reg              toggle_register_select_n,
    // Partner inputs
    input  wire             wait_req,
    input  wire [NREQ-1:0]  request_n,
    input  wire             sense_line_zero_n,
    input  wire             sense_line_one_n,
    input  wire             sense_line_two_n,
    input  wire             conditional_skip_sense_n,
    // Target of data transfers
    input  wire [1:0]       xfer_target,
    // Observation
    output reg  [2:0]       major_state,
    output reg              fetch_cycle,
    output reg  [NREQ-1:0]  request_grant,
    output wire [WIDTH-1:0] sum_holding_register,
    output wire             link_bit,
    output wire [WIDTH-1:0] instruction_pointer
);

    localparam SW = NREQ + 5;

    // Three-stage input capture; change accepted when stages two and three agree
    reg  [SW-1:0] s1_q;
    reg  [SW-1:0] s2_q;
    reg  [SW-1:0] s3_q;
    reg  [SW-1:0] in_q;
    wire [SW-1:0] raw = {request_n, sense_line_zero_n, sense_line_one_n,
                         sense_line_two_n, conditional_skip_sense_n,
                         wait_req};
    wire          wait_s   = in_q[0];
    wire          skip_s_n = in_q[1];
    wire [2:0]    ctl_s_n  = {in_q[2], in_q[3], in_q[4]}; // Bit n is line n
    wire [NREQ-1:0] req_s_n = in_q[SW-1:5];

    // Register set
    reg [WIDTH-1:0] acc_q; // RULE13
    reg             link_q;
    reg [WIDTH-1:0] mq_q;
    reg [WIDTH-1:0] ptr_q;
    reg [WIDTH-1:0] loc_q;
    reg [WIDTH-1:0] op_q;
    reg [WIDTH-1:0] data_q;

    reg       half_q;
    reg [2:0] st_q;
    reg [1:0] cy_q;
    reg [2:0] sense_q;
    reg       fetch_next_q;

    assign sum_holding_register = acc_q;
    assign link_bit             = link_q;
    assign instruction_pointer  = ptr_q;

    wire [2:0] opc      = op_q[11:9];
    wire       state_end = half_q & clk_en;
    wire       stall     = wait_s & ((st_q == `ST_XFER_IN) |
                                     (st_q == `ST_WRITE));

    // ALU on accumulator and one other operand
    wire [WIDTH:0] add_sum = {1'b0, acc_q} + {1'b0, data_q};
    wire [WIDTH:0] inc_sum = {1'b0, acc_q} + {{WIDTH{1'b0}}, 1'b1};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {SW{1'b1}} ^ {{(SW-1){1'b0}}, 1'b1};
            s2_q <= {SW{1'b1}} ^ {{(SW-1){1'b0}}, 1'b1};
            s3_q <= {SW{1'b1}} ^ {{(SW-1){1'b0}}, 1'b1};
            in_q <= {SW{1'b1}} ^ {{(SW-1){1'b0}}, 1'b1};
        end else if (clk_en) begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Hold while stages two and three differ
            in_q <= (in_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q       <= 1'b0;
            st_q         <= `ST_IDLE;
            cy_q         <= `CY_FETCH;
            acc_q        <= {WIDTH{1'b0}};
            link_q       <= 1'b0;
            mq_q         <= {WIDTH{1'b0}};
            ptr_q        <= `RESET_PTR;
            loc_q        <= {WIDTH{1'b0}};
            op_q         <= {WIDTH{1'b0}};
            data_q       <= {WIDTH{1'b0}};
            sense_q      <= 3'h7;
            fetch_next_q <= 1'b1;
            request_grant <= {NREQ{1'b0}};
        end else if (clk_en) begin
            // Divide by two; a stall holds the second half (RULE1 RULE7)
            if (!(half_q && stall))
                half_q <= ~half_q; // RULE1
            if (state_end && !stall) begin
                case (st_q)
                `ST_IDLE: st_q <= `ST_ADDR;
                `ST_ADDR: begin
                    if (cy_q == `CY_FETCH) begin
                        loc_q <= ptr_q; // RULE17
                        ptr_q <= ptr_q + 12'h001; // RULE21
                    end
                    if (fetch_next_q)
                        request_grant <= ~req_s_n & (~(~req_s_n) + 1'b1 &
                                         ~req_s_n); // RULE4
                    st_q <= (cy_q == `CY_MEM_WR) ? `ST_WRITE : `ST_XFER_IN;
                end
                `ST_XFER_IN: begin
                    data_q <= muxed_bus_in; // RULE6
                    if (cy_q == `CY_FETCH)
                        op_q <= muxed_bus_in; // RULE17
                    st_q <= `ST_ALU_A;
                end
                `ST_ALU_A: st_q <= `ST_ALU_B; // RULE11
                `ST_ALU_B: begin
                    // Sense lines lag by the capture stages: what they
                    // showed in transfer-in is settled only here
                    if (cy_q == `CY_IO) begin
                        sense_q <= ctl_s_n; // RULE9
                        if (!skip_s_n)
                            ptr_q <= ptr_q + 12'h001;
                        if (!ctl_s_n[0] && !ctl_s_n[1])
                            ptr_q <= data_q; // RULE19
                        if (!ctl_s_n[2])
                            acc_q <= data_q;
                    end
                    st_q <= `ST_ALU_C;
                end
                `ST_ALU_C: begin
                    st_q <= `ST_ADDR;
                    fetch_next_q <= 1'b1;
                    cy_q <= `CY_FETCH;
                    if (cy_q == `CY_FETCH) begin
                        case (opc)
                        `OP_AND, `OP_ADD: begin
                            cy_q <= `CY_MEM_RD;
                            fetch_next_q <= 1'b0;
                        end
                        `OP_DEP: begin
                            cy_q <= `CY_MEM_WR;
                            fetch_next_q <= 1'b0;
                            data_q <= acc_q;
                        end
                        `OP_JUMP: ptr_q <= op_q[8:0] |
                                           {ptr_q[11:9], 9'h000}; // RULE18
                        `OP_IO: begin
                            cy_q <= `CY_IO;
                            fetch_next_q <= 1'b0;
                        end
                        `OP_OPR: begin
                            // RULE15 RULE14 RULE20
                            if (op_q[7]) acc_q <= {WIDTH{1'b0}};
                            if (op_q[6]) link_q <= 1'b0;
                            if (op_q[5]) acc_q <= ~acc_q;
                            if (op_q[4]) link_q <= ~link_q;
                            if (op_q[0]) begin
                                acc_q <= inc_sum[WIDTH-1:0];
                                if (inc_sum[WIDTH]) link_q <= ~link_q;
                            end
                            if (op_q[3]) // Rotate right through link
                                {acc_q, link_q} <= {link_q, acc_q};
                            if (op_q[2]) // Rotate left through link
                                {link_q, acc_q} <= {acc_q, link_q};
                            if (op_q[8] && op_q[1]) // RULE16
                                acc_q <= acc_q | mq_q;
                            if (op_q[8] && op_q[1] && op_q[7]) begin
                                acc_q <= mq_q; // RULE16
                                mq_q  <= acc_q;
                            end
                            if (op_q[8] && !op_q[1] && op_q[7]) begin
                                acc_q <= {WIDTH{1'b1}};
                                link_q <= 1'b1;
                            end
                        end
                        default: ;
                        endcase
                    end else if (cy_q == `CY_MEM_RD) begin
                        if (opc == `OP_AND)
                            acc_q <= acc_q & data_q; // RULE20
                        else begin
                            acc_q <= add_sum[WIDTH-1:0]; // RULE15
                            if (add_sum[WIDTH])
                                link_q <= ~link_q; // RULE14
                        end
                    end
                end
                `ST_WRITE: begin
                    if (opc == `OP_DEP)
                        acc_q <= {WIDTH{1'b0}};
                    st_q <= `ST_ALU_A;
                end
                default: st_q <= `ST_IDLE;
                endcase
                if (st_q == `ST_ADDR && cy_q != `CY_FETCH)
                    loc_q <= {ptr_q[11:7], op_q[6:0]};
            end
        end
    end

    // Registered bus and status outputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            muxed_bus_out            <= {WIDTH{1'b0}};
            muxed_bus_oe             <= 1'b0;
            external_latch_strobe    <= 1'b0;
            memory_select_n          <= 1'b1;
            peripheral_select_n      <= 1'b1;
            panel_store_select_n     <= 1'b1;
            toggle_register_select_n <= 1'b1;
            major_state              <= `ST_IDLE;
            fetch_cycle              <= 1'b0;
        end else if (clk_en) begin
            major_state <= st_q; // RULE5
            fetch_cycle <= (cy_q == `CY_FETCH);
            external_latch_strobe <= (st_q == `ST_ADDR) & ~half_q; // RULE2
            muxed_bus_oe  <= 1'b0;
            muxed_bus_out <= {WIDTH{1'b0}};
            memory_select_n          <= 1'b1;
            peripheral_select_n      <= 1'b1;
            panel_store_select_n     <= 1'b1;
            toggle_register_select_n <= 1'b1;
            case (st_q)
            `ST_ADDR: begin
                muxed_bus_oe <= 1'b1;
                if (cy_q == `CY_IO)
                    muxed_bus_out <= op_q; // RULE3
                else if (cy_q == `CY_FETCH)
                    muxed_bus_out <= ptr_q; // RULE2
                else
                    muxed_bus_out <= {ptr_q[11:7], op_q[6:0]};
            end
            `ST_XFER_IN, `ST_WRITE: begin
                if (st_q == `ST_WRITE) begin
                    muxed_bus_oe  <= 1'b1; // RULE12
                    muxed_bus_out <= data_q;
                end
                if (cy_q == `CY_IO)
                    peripheral_select_n <= 1'b0; // RULE8
                else if (xfer_target == `TGT_PANEL)
                    panel_store_select_n <= 1'b0; // RULE10
                else if (xfer_target == `TGT_TOGGLE)
                    toggle_register_select_n <= 1'b0; // RULE10
                else
                    memory_select_n <= 1'b0; // RULE8
            end
            default: ;
            endcase
        end
    end

endmodule

// >>> tb/major_state_bus_sequencer_asserts.sv
/* Port checker for the major-state bus sequencer.
   Bound to each instance; sees only the sequencer's ports. */
`timescale 1ns/10ps
`include "seq_map.vh"
module seq_checker #(
    parameter NREQ = 3
) (
    // Clock and controls
    input wire            sys_clk,
    input wire            rst_n,
    input wire            clk_en,
    input wire            wait_req,
    // Outputs watched
    input wire            muxed_bus_oe,
    input wire            external_latch_strobe,
    input wire            memory_select_n,
    input wire            peripheral_select_n,
    input wire            panel_store_select_n,
    input wire            toggle_register_select_n,
    input wire [2:0]      major_state,
    input wire [NREQ-1:0] request_grant
);
    wire [3:0] sel = {memory_select_n, peripheral_select_n,
                      panel_store_select_n, toggle_register_select_n};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_state_min: assert property ($changed(major_state) |=>
        $stable(major_state)) else $error("state too short");
    a_addr_max: assert property (
        (major_state == `ST_ADDR && clk_en) [*2] |=>
        major_state != `ST_ADDR) else $error("address state too long");
    a_strobe_once: assert property (
        external_latch_strobe && clk_en |=> !external_latch_strobe)
        else $error("strobe longer than one clock");
    a_strobe_addr: assert property (external_latch_strobe |->
        muxed_bus_oe && major_state == `ST_ADDR)
        else $error("strobe outside driven address state");
    a_strobe_each: assert property (
        $rose(major_state == `ST_ADDR) |-> ##[0:3] external_latch_strobe)
        else $error("address state without strobe");
    a_sel_onehot: assert property ($onehot0(~sel))
        else $error("two selects active");
    a_sel_xfer: assert property (sel != 4'hf |->
        major_state inside {`ST_XFER_IN, `ST_WRITE})
        else $error("select outside transfer states");
    a_alu_quiet: assert property (
        major_state inside {`ST_ALU_B, `ST_ALU_C} |->
        sel == 4'hf && !external_latch_strobe)
        else $error("bus activity in internal state");
    a_wait_hold: assert property (
        (major_state == `ST_XFER_IN && wait_req) [*5] |=>
        major_state == `ST_XFER_IN) else $error("left state under wait");
    a_grant_one: assert property ($onehot0(request_grant))
        else $error("more than one grant");
    a_freeze_hold: assert property (!clk_en |=>
        $stable(major_state) && $stable(sel)) else $error("moved frozen");

    c_stall: cover property ((major_state == `ST_XFER_IN) [*6]);
    c_device: cover property (!peripheral_select_n);
    c_panel: cover property (!panel_store_select_n);
    c_grant: cover property (request_grant != 0);
endmodule
bind major_state_bus_sequencer seq_checker #(.NREQ(NREQ)) seq_checker_i (
    .sys_clk, .rst_n, .clk_en, .wait_req, .muxed_bus_oe,
    .external_latch_strobe, .memory_select_n, .peripheral_select_n,
    .panel_store_select_n, .toggle_register_select_n, .major_state,
    .request_grant);

// >>> tb/bus_partner.sv
/* Memory and peripheral model on the far side of the multiplexed bus.
   The bench steers stall, sense_mode and io_data. */
`timescale 1ns/10ps
module bus_partner (
    // Device side
    input  wire        sys_clk,
    input  wire [11:0] muxed_bus_out,
    input  wire        muxed_bus_oe,
    input  wire        external_latch_strobe,
    input  wire        memory_select_n,
    input  wire        peripheral_select_n,
    input  wire        panel_store_select_n,
    input  wire        toggle_register_select_n,
    output wire [11:0] muxed_bus_in,
    output wire        wait_req,
    output wire        sense_line_zero_n,
    output wire        sense_line_one_n,
    output wire        sense_line_two_n,
    output wire        conditional_skip_sense_n,
    // Bench controls
    input  wire        stall,
    input  wire [1:0]  sense_mode,
    input  wire [11:0] io_data
);
    reg  [11:0] mem [0:4095];
    reg  [11:0] addr_q;
    reg  [11:0] last_q;
    wire        rd  = !memory_select_n || !panel_store_select_n ||
                      !toggle_register_select_n;
    wire        dev = !peripheral_select_n;
    integer     k;

    // Empty memory reads as a no-op operate word
    initial begin
        for (k = 0; k < 4096; k = k + 1) begin
            mem[k] = 12'he00;
        end
    end
    always @(posedge sys_clk) begin
        if (external_latch_strobe) begin
            addr_q <= muxed_bus_out;
        end
        last_q <= muxed_bus_in;
    end
    // Undriven bus toggles so a stale word never passes as data
    assign muxed_bus_in = muxed_bus_oe ? ~last_q : rd ? mem[addr_q] :
                          dev ? io_data : ~last_q;
    assign wait_req = stall;
    assign conditional_skip_sense_n = !(dev && sense_mode == 2'h1);
    assign sense_line_zero_n = !(dev && sense_mode == 2'h2);
    assign sense_line_one_n = !(dev && sense_mode == 2'h2);
    assign sense_line_two_n = !(dev && sense_mode == 2'h3);
endmodule

// >>> tb/major_state_bus_sequencer_tb.sv
/* Self-checking bench for the major-state bus sequencer.
   Uses bus_partner and the bound checker; 50 ns clock. */
`timescale 1ns/10ps
`include "seq_map.vh"
`define CHK(nm, e, g) begin comparisons = comparisons + 1; \
    if ((g) !== (e)) begin err_total = err_total + 1; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module major_state_bus_sequencer_tb;
    reg         sys_clk, rst_n, clk_en, stall;
    reg  [2:0]  request_n;
    reg  [1:0]  xfer_target, sense_mode;
    reg  [11:0] io_data;
    wire [11:0] bin, bout;
    wire [2:0]  state, grant;
    wire        oe, strobe, msel_n, psel_n, csel_n, tsel_n, wait_req;
    wire        s0_n, s1_n, s2_n, skip_n;
    wire [11:0] acc, ptr;
    wire        link, fcyc;
    integer     err_total, comparisons, n, a;

    major_state_bus_sequencer major_state_bus_sequencer_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .muxed_bus_in(bin), .muxed_bus_out(bout), .muxed_bus_oe(oe),
        .external_latch_strobe(strobe), .memory_select_n(msel_n),
        .peripheral_select_n(psel_n), .panel_store_select_n(csel_n),
        .toggle_register_select_n(tsel_n), .wait_req(wait_req),
        .request_n(request_n), .sense_line_zero_n(s0_n),
        .sense_line_one_n(s1_n), .sense_line_two_n(s2_n),
        .conditional_skip_sense_n(skip_n), .xfer_target(xfer_target),
        .major_state(state), .fetch_cycle(fcyc), .request_grant(grant),
        .sum_holding_register(acc), .link_bit(link),
        .instruction_pointer(ptr));
    bus_partner partner_i (
        .sys_clk(sys_clk), .muxed_bus_out(bout), .muxed_bus_oe(oe),
        .external_latch_strobe(strobe), .memory_select_n(msel_n),
        .peripheral_select_n(psel_n), .panel_store_select_n(csel_n),
        .toggle_register_select_n(tsel_n), .muxed_bus_in(bin),
        .wait_req(wait_req), .sense_line_zero_n(s0_n),
        .sense_line_one_n(s1_n), .sense_line_two_n(s2_n),
        .conditional_skip_sense_n(skip_n), .stall(stall),
        .sense_mode(sense_mode), .io_data(io_data));

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // Wait for the first sample of a fresh address state
    task to_addr;
        begin
            n = 0;
            while (state === `ST_ADDR && n < 400) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            while (state !== `ST_ADDR && n < 400) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            `CHK("cycle start", 1'b1, n < 400)
        end
    endtask
    // One cycle: word on the bus, strobe, selects, state sequence
    task walk(input [11:0] word, input [3:0] sel, input full);
        integer i;
        reg     seen;
        begin
            to_addr;
            seen = strobe;
            for (i = 1; i < 10; i = i + 1) begin
                @(negedge sys_clk);
                if (i == 1) begin
                    seen = seen | strobe;
                    `CHK("bus word", {1'b1, word}, {oe, bout})
                    `CHK("strobe", 1'b1, seen)
                end
                if (i == 3) begin
                    `CHK("selects", sel, {msel_n, psel_n, csel_n, tsel_n})
                    `CHK("fetch flag", full, fcyc)
                end
                if (i < 4 || full)
                    `CHK("state", (i >> 1) + 1, state)
            end
        end
    endtask
    // Stall the read under wait, release, then freeze the clock enable
    task stall_and_freeze;
        reg [2:0] held;
        begin
            @(posedge sys_clk) stall <= 1'b1;
            n = 0;
            while (state !== `ST_XFER_IN && n < 40) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            repeat (16) @(negedge sys_clk);
            `CHK("stalled", {1'b0, `ST_XFER_IN}, {msel_n, state})
            @(posedge sys_clk) stall <= 1'b0;
            n = 0;
            while (state === `ST_XFER_IN && n < 40) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            `CHK("release", 1'b1, n < 8)
            @(posedge sys_clk) clk_en <= 1'b0;
            @(negedge sys_clk) held = state;
            repeat (8) @(negedge sys_clk);
            `CHK("frozen", held, state)
            @(posedge sys_clk) clk_en <= 1'b1;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        stall = 1'b0;
        request_n = 3'h7;
        xfer_target = 2'h0;
        sense_mode = 2'h1;
        io_data = 12'h040;
        repeat (5) @(posedge sys_clk);
        partner_i.mem[9] = 12'hc00;
        partner_i.mem[12] = 12'hc00;
        partner_i.mem[65] = 12'hc00;
        @(negedge sys_clk);
        `CHK("reset outs", 8'hf0, {msel_n, psel_n, csel_n, tsel_n, oe, state})
        @(posedge sys_clk) rst_n <= 1'b1;
        for (a = 0; a < 4; a = a + 1)
            walk(`RESET_PTR + a, 4'h7, 1'b1);
        for (a = 1; a < 3; a = a + 1) begin
            @(posedge sys_clk) xfer_target <= a;
            walk(12'h003 + a, (a == 1) ? 4'hd : 4'he, 1'b1);
        end
        @(posedge sys_clk) xfer_target <= 2'h0;
        stall_and_freeze;
        walk(12'h008, 4'h7, 1'b1);
        walk(12'h009, 4'h7, 1'b1);
        walk(12'hc00, 4'hb, 1'b0);
        walk(12'h00b, 4'h7, 1'b1);
        @(posedge sys_clk) sense_mode <= 2'h2;
        walk(12'h00c, 4'h7, 1'b1);
        walk(12'hc00, 4'hb, 1'b0);
        walk(12'h040, 4'h7, 1'b1);
        @(posedge sys_clk) sense_mode <= 2'h3;
        walk(12'h041, 4'h7, 1'b1);
        walk(12'hc00, 4'hb, 1'b0);
        `CHK("acc load", 13'h0040, {link, acc})
        `CHK("pointer", 12'h042, ptr)
        @(posedge sys_clk) request_n <= 3'h4;
        n = 0;
        while (grant === 3'h0 && n < 200) begin
            @(negedge sys_clk);
            n = n + 1;
        end
        `CHK("grant", 3'h1, grant)
        tally_and_finish;
    end
endmodule
